// ==== verilog/prox_sensor_ctrl.sv ====
// serial slave, register file, cancellation and threshold interrupt of the proximity sensor
// Notes on behaviour
// - answer only slave address 0x60, ignore every other address.
// - all access is a command code then one two-byte word.
// - acknowledge every address, command and data byte sent to us.
// - reading the flag word clears the pending interrupt and, in interrupt mode (10), releases alert.
// - when enabled, interrupt on result above high or below low threshold.
// - interrupt only after persistence-count consecutive out-of-threshold samples.
// - flag bits show whether a high or low crossing caused the interrupt.
// - subtract the 16-bit cancellation word from each measurement.
// - smart persistence cuts a persistence of 3 or 4 samples down to two.
// - result is 12 bits in low and high bytes, read as one word.
// - standby low byte and prox_cfg_a reset to 0x01, others to 0x00.
// - result, flags, identity and calibration words are read-only.
// - prox_cfg_b holds integration time, multi-pulse and interrupt options.
// - word 0x04 holds force mode, sunlight interrupt and emitter current.
// - word 0x08 holds auto-calibration settings and low-power mode.
// - calibration result high byte carries result MSBs, busy and sunlight.
// - low threshold at 0x05, high threshold at 0x06, 16 bits each.
// - irq_mode_field 00 off, 01 level mode, 10 interrupt, 11 reserved.
// - persistence field 00..11 needs 1..4 consecutive samples.
`default_nettype none
module prox_sensor_ctrl
   import prox_pkg::*;
(
   input wire logic ref_clk,
   input wire logic arst_n,
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe,
   output logic alert_out,
   output logic alert_oe,
   input wire logic sample_valid,
   input wire logic [RESULT_W-1:0] sample_raw,
   input wire logic [15:0] autocal_data,
   output logic [15:0] standby_word,
   output logic [15:0] prox_cfg_ab,
   output logic [15:0] prox_cfg_cd,
   output logic [15:0] autocal_word
);
   typedef enum logic [2:0] {
      ST_IDLE, ST_ADDR, ST_CMD, ST_WDAT, ST_ACK, ST_RDAT, ST_MACK
   } bus_state_t;

   // ==========================================
   // pin synchronisers and bus conditions
   logic [1:0] scl_sync_ff;
   logic [1:0] sda_sync_ff;
   logic scl_d_ff;
   logic sda_d_ff;
   logic scl_rise;
   logic scl_fall;
   logic bus_start;
   logic bus_stop;
   logic sda_bit;

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         scl_sync_ff <= 2'h3;
         sda_sync_ff <= 2'h3;
         scl_d_ff <= 1'b1;
         sda_d_ff <= 1'b1;
      end else begin
         scl_sync_ff <= {scl_sync_ff[0], scl_in};
         sda_sync_ff <= {sda_sync_ff[0], sda_in};
         scl_d_ff <= scl_sync_ff[1];
         sda_d_ff <= sda_sync_ff[1];
      end
   end

   // only the second stage is looked at, the first may be metastable
   assign sda_bit = sda_sync_ff[1];
   assign scl_rise = scl_sync_ff[1] && !scl_d_ff;
   assign scl_fall = !scl_sync_ff[1] && scl_d_ff;
   assign bus_start = scl_sync_ff[1] && scl_d_ff && sda_d_ff && !sda_bit;
   assign bus_stop = scl_sync_ff[1] && scl_d_ff && !sda_d_ff && sda_bit;

   // ==========================================
   // register storage
   logic [15:0] standby_ff;
   logic [15:0] prox_ab_ff;
   logic [15:0] prox_cd_ff;
   logic [15:0] low_th_ff;
   logic [15:0] high_th_ff;
   logic [15:0] cancel_ff;
   logic [15:0] autocal_ff;
   logic [RESULT_W-1:0] result_ff;
   logic [7:0] flags_ff;
   logic [7:0] wr_low_ff;

   // ==========================================
   // serial slave state
   bus_state_t state_ff;
   bus_state_t ack_next_ff;
   logic [3:0] bit_cnt_ff;
   logic [7:0] shift_ff;
   logic [7:0] tx_ff;
   logic [7:0] cmd_ff;
   logic [1:0] byte_idx_ff;
   logic [15:0] shadow_ff;
   logic oe_ff;
   logic byte_end;
   logic addr_hit;
   logic rd_snap;
   logic wr_byte;
   logic [15:0] rd_mux;
   logic [7:0] next_tx;

   assign byte_end = scl_fall && (bit_cnt_ff == 4'h8);
   assign addr_hit = (shift_ff[7:1] == SLAVE_ADDR);
   assign rd_snap = (state_ff == ST_ADDR) && byte_end && addr_hit && shift_ff[0];
   assign wr_byte = (state_ff == ST_WDAT) && byte_end && !bus_start && !bus_stop;
   // low byte first, then high
   assign next_tx = byte_idx_ff[0] ? shadow_ff[15:8] : shadow_ff[7:0];

   // read side of the word map; unknown codes read as zero
   always_comb begin
      unique case (cmd_ff)
         CMD_STANDBY: rd_mux = standby_ff;
         CMD_PROX_AB: rd_mux = prox_ab_ff;
         CMD_PROX_CD: rd_mux = prox_cd_ff;
         CMD_LOW_TH: rd_mux = low_th_ff;
         CMD_HIGH_TH: rd_mux = high_th_ff;
         CMD_CANCEL: rd_mux = cancel_ff;
         CMD_AUTOCAL: rd_mux = autocal_ff;
         CMD_RESULT: rd_mux = {{(16 - RESULT_W){1'b0}}, result_ff};
         CMD_FLAGS: rd_mux = {flags_ff, 8'h00};
         CMD_IDENT: rd_mux = PART_IDENT;
         CMD_CAL_RES: rd_mux = autocal_data;
         default: rd_mux = 16'h0000;
      endcase
   end

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         state_ff <= ST_IDLE;
         ack_next_ff <= ST_IDLE;
         bit_cnt_ff <= 4'h0;
         shift_ff <= 8'h00;
         tx_ff <= 8'h00;
         cmd_ff <= 8'h00;
         byte_idx_ff <= 2'h0;
         shadow_ff <= 16'h0000;
         oe_ff <= 1'b0;
      end else if (bus_stop) begin
         state_ff <= ST_IDLE;
         oe_ff <= 1'b0;
      end else if (bus_start) begin
         // repeated start keeps the command code for a following read
         state_ff <= ST_ADDR;
         bit_cnt_ff <= 4'h0;
         oe_ff <= 1'b0;
      end else begin
         unique case (state_ff)
            ST_IDLE: begin
               oe_ff <= 1'b0;
            end
            ST_ADDR, ST_CMD, ST_WDAT: begin
               if (scl_rise) begin
                  shift_ff <= {shift_ff[6:0], sda_bit};
                  bit_cnt_ff <= bit_cnt_ff + 4'h1;
               end else if (byte_end) begin
                  bit_cnt_ff <= 4'h0;
                  if (state_ff == ST_ADDR) begin
                     if (addr_hit) begin
                        oe_ff <= 1'b1;
                        state_ff <= ST_ACK;
                        ack_next_ff <= shift_ff[0] ? ST_RDAT : ST_CMD;
                        byte_idx_ff <= 2'h0;
                        if (shift_ff[0]) begin
                           shadow_ff <= rd_mux;
                        end
                     end else begin
                        state_ff <= ST_IDLE;
                     end
                  end else if (state_ff == ST_CMD) begin
                     cmd_ff <= shift_ff;
                     oe_ff <= 1'b1;
                     state_ff <= ST_ACK;
                     ack_next_ff <= ST_WDAT;
                     byte_idx_ff <= 2'h0;
                  end else begin
                     oe_ff <= 1'b1;
                     state_ff <= ST_ACK;
                     ack_next_ff <= ST_WDAT;
                     if (byte_idx_ff != 2'h2) begin
                        byte_idx_ff <= byte_idx_ff + 2'h1;
                     end
                  end
               end
            end
            ST_ACK: begin
               if (scl_fall) begin
                  state_ff <= ack_next_ff;
                  if (ack_next_ff == ST_RDAT) begin
                     oe_ff <= !next_tx[7];
                     tx_ff <= {next_tx[6:0], 1'b0};
                     bit_cnt_ff <= 4'h1;
                     byte_idx_ff <= 2'h1;
                  end else begin
                     oe_ff <= 1'b0;
                  end
               end
            end
            ST_RDAT: begin
               if (scl_fall) begin
                  if (bit_cnt_ff == 4'h8) begin
                     oe_ff <= 1'b0;
                     state_ff <= ST_MACK;
                  end else begin
                     oe_ff <= !tx_ff[7];
                     tx_ff <= {tx_ff[6:0], 1'b0};
                     bit_cnt_ff <= bit_cnt_ff + 4'h1;
                  end
               end
            end
            ST_MACK: begin
               if (scl_rise && sda_bit) begin
                  state_ff <= ST_IDLE;
               end else if (scl_fall) begin
                  // words repeat low, high, low... while the host keeps acking
                  state_ff <= ST_RDAT;
                  oe_ff <= !next_tx[7];
                  tx_ff <= {next_tx[6:0], 1'b0};
                  bit_cnt_ff <= 4'h1;
                  byte_idx_ff <= {1'b0, !byte_idx_ff[0]};
               end
            end
            default: state_ff <= ST_IDLE;
         endcase
      end
   end

   // open drain: only ever pull low
   assign sda_out = 1'b0;
   assign sda_oe = oe_ff;

   // ==========================================
   // register writes
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         standby_ff <= RST_STANDBY;
         prox_ab_ff <= RST_PROX_AB;
         prox_cd_ff <= RST_OTHER;
         low_th_ff <= RST_OTHER;
         high_th_ff <= RST_OTHER;
         cancel_ff <= RST_OTHER;
         autocal_ff <= RST_OTHER;
         wr_low_ff <= 8'h00;
      end else if (wr_byte) begin
         if (byte_idx_ff == 2'h0) begin
            wr_low_ff <= shift_ff;
         end else if (byte_idx_ff == 2'h1) begin
            // word commits on the high byte; read-only codes fall through
            unique case (cmd_ff)
               CMD_STANDBY: standby_ff <= {shift_ff, wr_low_ff};
               CMD_PROX_AB: prox_ab_ff <= {shift_ff, wr_low_ff};
               CMD_PROX_CD: prox_cd_ff <= {shift_ff, wr_low_ff};
               CMD_LOW_TH: low_th_ff <= {shift_ff, wr_low_ff};
               CMD_HIGH_TH: high_th_ff <= {shift_ff, wr_low_ff};
               CMD_CANCEL: cancel_ff <= {shift_ff, wr_low_ff};
               CMD_AUTOCAL: autocal_ff <= {shift_ff, wr_low_ff};
               default: wr_low_ff <= wr_low_ff;
            endcase
         end
      end
   end

   assign standby_word = standby_ff;
   assign prox_cfg_ab = prox_ab_ff;
   assign prox_cfg_cd = prox_cd_ff;
   assign autocal_word = autocal_ff;

   // ==========================================
   // measurement, cancellation and persistence
   logic [16:0] diff;
   logic [RESULT_W-1:0] corrected;
   logic running;
   logic [1:0] irq_mode;
   logic [2:0] need;
   logic above;
   logic below;
   logic [2:0] high_cnt_ff;
   logic [2:0] low_cnt_ff;
   logic high_evt;
   logic low_evt;
   logic level_ff;

   // clamp at zero instead of wrapping
   assign diff = {5'h00, sample_raw} - {1'b0, cancel_ff};
   assign corrected = diff[16] ? '0 : diff[RESULT_W-1:0];
   assign running = !prox_ab_ff[START_BIT];
   assign irq_mode = prox_ab_ff[IRQ_MODE_LSB +: 2];
   assign need = (prox_ab_ff[SMART_BIT] && ({1'b0, prox_ab_ff[PERS_LSB +: 2]} > 3'h1))
      ? SMART_NEED : {1'b0, prox_ab_ff[PERS_LSB +: 2]} + 3'h1;
   assign above = {4'h0, corrected} > high_th_ff;
   assign below = {4'h0, corrected} < low_th_ff;
   // fires once per excursion, on the sample that reaches the count
   assign high_evt = sample_valid && running && above && (high_cnt_ff + 3'h1 == need);
   assign low_evt = sample_valid && running && below && (low_cnt_ff + 3'h1 == need);

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         result_ff <= '0;
         high_cnt_ff <= 3'h0;
         low_cnt_ff <= 3'h0;
      end else if (sample_valid && running) begin
         result_ff <= corrected;
         high_cnt_ff <= !above ? 3'h0 : (high_cnt_ff == 3'h4 ? 3'h4 : high_cnt_ff + 3'h1);
         low_cnt_ff <= !below ? 3'h0 : (low_cnt_ff == 3'h4 ? 3'h4 : low_cnt_ff + 3'h1);
      end
   end

   // ==========================================
   // event flags and alert pin
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         flags_ff <= 8'h00;
      end else if (irq_mode == IRQ_MODE_OFF || irq_mode == IRQ_MODE_LEVEL ||
                   irq_mode == IRQ_MODE_EVENT) begin
         // a new crossing in the read cycle survives the clear
         flags_ff[FLAG_HIGH_BIT] <= (irq_mode != IRQ_MODE_OFF && high_evt) ||
            (flags_ff[FLAG_HIGH_BIT] && !(rd_snap && cmd_ff == CMD_FLAGS));
         flags_ff[FLAG_LOW_BIT] <= (irq_mode != IRQ_MODE_OFF && low_evt) ||
            (flags_ff[FLAG_LOW_BIT] && !(rd_snap && cmd_ff == CMD_FLAGS));
      end else if (rd_snap && cmd_ff == CMD_FLAGS) begin
         flags_ff <= 8'h00;
      end
   end

   // level mode follows the last persisted crossing, with hysteresis
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         level_ff <= 1'b0;
      end else if (high_evt) begin
         level_ff <= 1'b1;
      end else if (low_evt) begin
         level_ff <= 1'b0;
      end
   end

   logic alert_ff;

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         alert_ff <= 1'b0;
      end else begin
         unique case (irq_mode)
            IRQ_MODE_LEVEL: alert_ff <= level_ff;
            IRQ_MODE_EVENT: alert_ff <= |flags_ff;
            default: alert_ff <= 1'b0;
         endcase
      end
   end

   // active-low open-drain alert
   assign alert_out = 1'b0;
   assign alert_oe = alert_ff;
endmodule
`default_nettype wire

// ==== verilog/prox_pkg.sv ====
// constants for the proximity sensor register and serial slave block
`default_nettype none
package prox_pkg;
   // ==========================================
   // bus address and command codes
   localparam logic [6:0] SLAVE_ADDR = 7'h60;
   localparam logic [7:0] CMD_STANDBY = 8'h00;
   localparam logic [7:0] CMD_PROX_AB = 8'h03;
   localparam logic [7:0] CMD_PROX_CD = 8'h04;
   localparam logic [7:0] CMD_LOW_TH = 8'h05;
   localparam logic [7:0] CMD_HIGH_TH = 8'h06;
   localparam logic [7:0] CMD_CANCEL = 8'h07;
   localparam logic [7:0] CMD_AUTOCAL = 8'h08;
   localparam logic [7:0] CMD_RESULT = 8'hf8;
   localparam logic [7:0] CMD_FLAGS = 8'hf9;
   localparam logic [7:0] CMD_IDENT = 8'hfa;
   localparam logic [7:0] CMD_CAL_RES = 8'hfb;
   // ==========================================
   // reset values of the writable words, high byte then low byte
   localparam logic [15:0] RST_STANDBY = 16'h0001;
   localparam logic [15:0] RST_PROX_AB = 16'h0001;
   localparam logic [15:0] RST_OTHER = 16'h0000;
   // ==========================================
   // fields of the low configuration byte (prox_cfg_a)
   localparam int START_BIT = 0;
   localparam int SMART_BIT = 1;
   localparam int IRQ_MODE_LSB = 2;
   localparam int PERS_LSB = 4;
   localparam logic [1:0] IRQ_MODE_OFF = 2'h0;
   localparam logic [1:0] IRQ_MODE_LEVEL = 2'h1;
   localparam logic [1:0] IRQ_MODE_EVENT = 2'h2;
   localparam logic [2:0] SMART_NEED = 3'h2;
   // ==========================================
   // event flag bits (high byte of the flag word)
   localparam int FLAG_HIGH_BIT = 1;
   localparam int FLAG_LOW_BIT = 0;
   // identity word: value is arbitrary
   localparam logic [15:0] PART_IDENT = 16'h5a3c;
   localparam int RESULT_W = 12;
endpackage
`default_nettype wire

// ==== sim/prox_host_model.sv ====
// serial bus host model that drives the sensor's clock and data pins
`default_nettype none
module prox_host_model
   import prox_pkg::*;
(
   input wire logic ref_clk,
   input wire logic sda_wire,
   output logic scl,
   output logic sda_drv
);
   // ==========================================
   // bit level: a quarter of the 320 ns bus period is two ref_clk cycles
   initial begin
      scl = 1'b1;
      sda_drv = 1'b1;
   end
   task automatic q();
      repeat (2) @(negedge ref_clk);
   endtask
   // start and repeated start alike; the trailing wait keeps data still while the clock falls
   task automatic strt();
      sda_drv = 1'b1;
      q();
      scl = 1'b1;
      q();
      sda_drv = 1'b0;
      q();
      scl = 1'b0;
      q();
   endtask
   task automatic stp();
      sda_drv = 1'b0;
      q();
      scl = 1'b1;
      q();
      sda_drv = 1'b1;
      q();
   endtask
   task automatic bit_io(input logic b, output logic r);
      sda_drv = b;
      q();
      scl = 1'b1;
      q();
      r = sda_wire;
      q();
      scl = 1'b0;
      q();
   endtask
   // sending all ones releases the line, so the same task reads
   task automatic byte_io(input logic [7:0] d, input logic last, output logic [7:0] r,
                          output logic ack);
      logic b;
      for (int i = 7; i >= 0; i--) begin
         bit_io(d[i], b);
         r[i] = b;
      end
      bit_io(last, b);
      ack = !b;
   endtask
   // ==========================================
   // word transfers
   task automatic wr_word(input logic [6:0] a, input logic [7:0] c, input logic [15:0] d,
                          output logic [3:0] ak);
      logic [7:0] r;
      strt();
      byte_io({a, 1'b0}, 1'b1, r, ak[3]);
      byte_io(c, 1'b1, r, ak[2]);
      byte_io(d[7:0], 1'b1, r, ak[1]);
      byte_io(d[15:8], 1'b1, r, ak[0]);
      stp();
   endtask
   task automatic rd_word(input logic [7:0] c, output logic [15:0] d,
                          output logic [2:0] ak);
      logic x;
      strt();
      byte_io({SLAVE_ADDR, 1'b0}, 1'b1, d[7:0], ak[2]);
      byte_io(c, 1'b1, d[7:0], ak[1]);
      strt();
      byte_io({SLAVE_ADDR, 1'b1}, 1'b1, d[7:0], ak[0]);
      byte_io(8'hff, 1'b0, d[7:0], x);
      byte_io(8'hff, 1'b1, d[15:8], x);
      stp();
   endtask
endmodule
`default_nettype wire

// ==== sim/prox_sensor_ctrl_checker.sv ====
// assertion checker for the proximity sensor control block
`default_nettype none
module prox_sensor_ctrl_checker
   import prox_pkg::*;
(
   input wire logic ref_clk,
   input wire logic arst_n,
   input wire logic scl_in,
   input wire logic sda_in,
   input wire logic sda_out,
   input wire logic sda_oe,
   input wire logic alert_out,
   input wire logic alert_oe,
   input wire logic sample_valid,
   input wire logic [RESULT_W-1:0] sample_raw,
   input wire logic [15:0] autocal_data,
   input wire logic [15:0] standby_word,
   input wire logic [15:0] prox_cfg_ab,
   input wire logic [15:0] prox_cfg_cd,
   input wire logic [15:0] autocal_word
);
   // ==========================================
   // recent sample pulses: alert may only rise a few cycles after one
   logic [5:0] hist_ff;
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         hist_ff <= 6'h00;
      end else begin
         hist_ff <= {hist_ff[4:0], sample_valid};
      end
   end
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!arst_n);
   // ==========================================
   // properties
   property p_reset_vals;
      $rose(arst_n) |-> standby_word == RST_STANDBY && prox_cfg_ab == RST_PROX_AB
         && prox_cfg_cd == RST_OTHER && autocal_word == RST_OTHER;
   endproperty
   a_reset_vals: assert property (p_reset_vals) else $error("bad reset value");
   property p_ack_low;
      $rose(sda_oe) |-> $past(scl_in, 2) == 1'b0;
   endproperty
   a_ack_low: assert property (p_ack_low) else $error("data pulled while clock high");
   property p_commit_low;
      $changed({standby_word, prox_cfg_ab, prox_cfg_cd, autocal_word}) |-> !$past(scl_in);
   endproperty
   a_commit_low: assert property (p_commit_low) else $error("write off the ack");
   property p_one_word;
      $onehot0({$changed(standby_word), $changed(prox_cfg_ab), $changed(prox_cfg_cd),
                $changed(autocal_word)});
   endproperty
   a_one_word: assert property (p_one_word) else $error("two words written at once");
   property p_alert_cause;
      $rose(alert_oe) |-> hist_ff != 6'h00 && !prox_cfg_ab[START_BIT];
   endproperty
   a_alert_cause: assert property (p_alert_cause) else $error("alert without sample");
   property p_alert_fall;
      $fell(alert_oe) |-> !$past(scl_in) || hist_ff != 6'h00;
   endproperty
   a_alert_fall: assert property (p_alert_fall) else $error("alert dropped unprompted");
   property p_mode_quiet;
      (prox_cfg_ab[3:2] == IRQ_MODE_OFF) [*2] |-> !alert_oe;
   endproperty
   a_mode_quiet: assert property (p_mode_quiet) else $error("alert while disabled");
   property p_pins_low;
      !sda_out && !alert_out;
   endproperty
   a_pins_low: assert property (p_pins_low) else $error("open drain pin driven high");
   c_alert: cover property ($rose(alert_oe));
   c_ack: cover property ($rose(sda_oe));
   c_write: cover property ($changed(prox_cfg_ab));
endmodule
bind prox_sensor_ctrl prox_sensor_ctrl_checker prox_sensor_ctrl_checker_i (
   .ref_clk, .arst_n, .scl_in, .sda_in, .sda_out, .sda_oe, .alert_out, .alert_oe,
   .sample_valid, .sample_raw, .autocal_data, .standby_word, .prox_cfg_ab, .prox_cfg_cd,
   .autocal_word);
`default_nettype wire

// ==== sim/prox_sensor_ctrl_tb.sv ====
// self-checking bench for the proximity sensor control block
`default_nettype none
module prox_sensor_ctrl_tb
   import prox_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic ref_clk = 1'b0;
   logic arst_n = 1'b0;
   logic sample_valid = 1'b0;
   logic [RESULT_W-1:0] sample_raw = 12'h000;
   logic [15:0] autocal_data = 16'hc35a;
   logic scl, sda_drv, sda_oe, sda_out, alert_oe, alert_out;
   logic [15:0] standby_word, prox_cfg_ab, prox_cfg_cd, autocal_word, rv;
   logic [3:0] ak;
   wire logic sda_line = sda_drv & ~sda_oe;
   int failures = 0;
   int n_checks = 0;
   // reserved bits are written at their defaults
   logic [7:0] wc [7] = '{CMD_STANDBY, CMD_PROX_AB, CMD_PROX_CD, CMD_LOW_TH, CMD_HIGH_TH,
                          CMD_CANCEL, CMD_AUTOCAL};
   logic [15:0] wv [7] = '{16'h0283, 16'hfc39, 16'h4a50, 16'h0123, 16'h0fed, 16'h00a5,
                           16'h0311};
   always #20 ref_clk = ~ref_clk;
   prox_sensor_ctrl prox_sensor_ctrl_i (.ref_clk, .arst_n, .scl_in(scl), .sda_in(sda_line),
      .sda_out, .sda_oe, .alert_out, .alert_oe, .sample_valid, .sample_raw, .autocal_data,
      .standby_word, .prox_cfg_ab, .prox_cfg_cd, .autocal_word);
   prox_host_model prox_host_model_i (.ref_clk, .sda_wire(sda_line), .scl, .sda_drv);
   // ==========================================
   // tasks
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_checks++;
      if (got !== exp) begin
         failures++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic chk_alert(input logic e);
      chk({15'h0000, alert_oe}, {15'h0000, e});
   endtask
   task automatic wr(input logic [7:0] c, input logic [15:0] d);
      prox_host_model_i.wr_word(SLAVE_ADDR, c, d, ak);
      chk({12'h000, ak}, 16'h000f);
   endtask
   task automatic rd(input logic [7:0] c, input logic [15:0] e);
      logic [2:0] a;
      prox_host_model_i.rd_word(c, rv, a);
      chk({13'h0000, a}, 16'h0007);
      chk(rv, e);
   endtask
   // the sample pulse lasts one cycle; alert settles well inside the wait after it
   task automatic smp(input logic [11:0] raw);
      @(negedge ref_clk);
      sample_valid = 1'b1;
      sample_raw = raw;
      @(negedge ref_clk);
      sample_valid = 1'b0;
      repeat (4) @(negedge ref_clk);
   endtask
   task automatic done(input string s);
      $display("test %s ended: checks=%0d failures=%0d", s, n_checks, failures);
   endtask
   task automatic end_of_test();
      $display("checks=%0d failures=%0d", n_checks, failures);
      if (failures == 0 && n_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   // ==========================================
   // tests
   initial begin
      repeat (100000) @(posedge ref_clk);
      failures++;
      end_of_test();
   end
   initial begin
      repeat (5) @(negedge ref_clk);
      arst_n = 1'b1;
      repeat (4) @(negedge ref_clk);
      chk(standby_word, RST_STANDBY);
      for (int i = 0; i < 7; i++) rd(wc[i], i == 0 ? RST_STANDBY : (i == 1 ? RST_PROX_AB : RST_OTHER));
      rd(CMD_IDENT, PART_IDENT);
      rd(CMD_CAL_RES, autocal_data);
      rd(CMD_FLAGS, 16'h0000);
      done("reset");
      for (int i = 0; i < 7; i++) wr(wc[i], wv[i]);
      for (int i = 0; i < 7; i++) rd(wc[i], wv[i]);
      chk(standby_word, wv[0]);
      chk(prox_cfg_ab, wv[1]);
      chk(prox_cfg_cd, wv[2]);
      chk(autocal_word, wv[6]);
      wr(CMD_RESULT, 16'h1234);
      rd(CMD_RESULT, 16'h0000);
      wr(CMD_IDENT, 16'h0000);
      rd(CMD_IDENT, PART_IDENT);
      prox_host_model_i.wr_word(7'h61, CMD_LOW_TH, 16'h0777, ak);
      chk({12'h000, ak}, 16'h0000);
      rd(CMD_LOW_TH, wv[3]);
      done("registers");
      wr(CMD_PROX_AB, 16'h0000);
      smp(12'h123);
      rd(CMD_RESULT, 16'h007e);
      smp(12'h0a0);
      rd(CMD_RESULT, 16'h0000);
      wr(CMD_CANCEL, 16'h0000);
      smp(12'hfff);
      rd(CMD_RESULT, 16'h0fff);
      chk_alert(1'b0);
      rd(CMD_FLAGS, 16'h0000);
      done("result");
      // the last result sample already counted one high sample; end that excursion first
      smp(12'h500);
      // the in-range sample at the end of each pass ends the excursion
      for (int p = 0; p < 4; p++) begin
         wr(CMD_PROX_AB, {8'h00, 2'b00, 2'(p), IRQ_MODE_EVENT, 2'b00});
         repeat (p) smp(12'hff0);
         chk_alert(1'b0);
         smp(12'hff0);
         chk_alert(1'b1);
         rd(CMD_FLAGS, 16'h0001 << (8 + FLAG_HIGH_BIT));
         chk_alert(1'b0);
         rd(CMD_FLAGS, 16'h0000);
         smp(12'h500);
      end
      wr(CMD_PROX_AB, {8'h00, 2'b00, 2'b11, IRQ_MODE_EVENT, 2'b10});
      smp(12'h010);
      chk_alert(1'b0);
      smp(12'h010);
      chk_alert(1'b1);
      rd(CMD_FLAGS, 16'h0001 << (8 + FLAG_LOW_BIT));
      smp(12'h500);
      done("persistence");
      wr(CMD_PROX_AB, {8'h00, 4'h0, IRQ_MODE_LEVEL, 2'b00});
      smp(12'hff0);
      chk_alert(1'b1);
      rd(CMD_FLAGS, 16'h0001 << (8 + FLAG_HIGH_BIT));
      chk_alert(1'b1);
      smp(12'h010);
      chk_alert(1'b0);
      rd(CMD_FLAGS, 16'h0001 << (8 + FLAG_LOW_BIT));
      done("level");
      @(negedge ref_clk);
      arst_n = 1'b0;
      repeat (2) @(negedge ref_clk);
      arst_n = 1'b1;
      repeat (4) @(negedge ref_clk);
      chk(prox_cfg_ab, RST_PROX_AB);
      rd(CMD_HIGH_TH, RST_OTHER);
      done("second reset");
      end_of_test();
   end
endmodule
`default_nettype wire
